// ### move_exec_pkg.sv
// constants and types shared by the data-move execution block
// ==========================================================================
// Behaviour
// - a pointer load copies the addressed byte to acc and sets zero from it.
// - a pointer store writes acc to the addressed byte, flags left alone.
// - update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - the pre modes step the pointer first and use the stepped value.
// - a pointer ends at old plus or minus one, unchanged in offset form.
// - offset form addresses pointer plus -32 to 31, pointer untouched.
// - either pointer, index 0 or 1, can be the address source.
// - the two alias file addresses reach the byte their pointer holds.
// - each pointer is 16 bits and wraps at either end.
// - stepping a pointer never changes any status bit.
// - the 5-bit bank literal loads the bank selector, flags unchanged.
// - the 7-bit page literal loads the upper jump latch, flags unchanged.
// - the 8-bit literal loads acc in one cycle, flags unchanged.
// - acc is written to the 7-bit file address in one cycle, flags kept.
package move_exec_pkg;

  // ========================================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0c;
  localparam logic [7:0] OFF_PAGE = 8'h10;
  localparam logic [7:0] OFF_PTR0 = 8'h14;
  localparam logic [7:0] OFF_PTR1 = 8'h18;
  localparam logic [7:0] OFF_MADDR = 8'h1c;
  localparam logic [7:0] OFF_MDATA = 8'h20;
  localparam logic [7:0] OFF_PC = 8'h24;

  // ========================================================================
  // instruction word fields
  localparam int OP_LSB = 0;
  localparam int OP_W = 3;
  localparam int PSEL_BIT = 3;
  localparam int MODE_LSB = 4;
  localparam int REL_BIT = 6;
  localparam int LIT_LSB = 8;

  // status bits
  localparam int STAT_C = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_Z = 2;
  localparam int STAT_W = 3;

  // ========================================================================
  // widths and reset values
  localparam int PTR_W = 16;
  localparam int BANK_W = 5;
  localparam int PAGE_W = 7;
  localparam int FILE_W = 7;
  localparam int OFFS_W = 6;
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam int NUM_PTR = 2;
  localparam logic [FILE_W-1:0] ALIAS0 = 7'h00;
  localparam logic [FILE_W-1:0] ALIAS1 = 7'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PTR_W-1:0] RST_PTR = 16'h0000;
  localparam logic [STAT_W-1:0] RST_STAT = 3'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ========================================================================
  // opcodes and pointer update codes
  typedef enum logic [OP_W-1:0] {
    OP_NOP = 3'b000,
    OP_LOAD_PTR = 3'b001,
    OP_STORE_PTR = 3'b010,
    OP_SET_BANK = 3'b011,
    OP_SET_PAGE = 3'b100,
    OP_LOAD_LIT = 3'b101,
    OP_STORE_FILE = 3'b110,
    OP_RSVD = 3'b111
  } op_e;

  typedef enum logic [1:0] {
    MODE_PRE_INC = 2'b00,
    MODE_PRE_DEC = 2'b01,
    MODE_POST_INC = 2'b10,
    MODE_POST_DEC = 2'b11
  } mode_e;

endpackage : move_exec_pkg

// ### pointer_step.sv
// effective address and next value of one file pointer
`timescale 1ns/1ps
module pointer_step
  import move_exec_pkg::*;
(
  // pointer and addressing form
  input wire logic [PTR_W-1:0] ptr,
  input wire logic [1:0] mode,
  input wire logic rel,
  input wire logic [OFFS_W-1:0] offset,
  // results
  output logic [PTR_W-1:0] eff_addr,
  output logic [PTR_W-1:0] next_ptr
);

  logic [PTR_W-1:0] stepped;
  logic [PTR_W-1:0] offs_ext;

  // 16-bit sums drop the carry, so both ends wrap
  assign stepped = mode[0] ? ptr - 16'h0001 : ptr + 16'h0001;
  assign offs_ext = {{(PTR_W-OFFS_W){offset[OFFS_W-1]}}, offset};

  always_comb
  begin
    if (rel)
    begin
      eff_addr = ptr + offs_ext;
      next_ptr = ptr;
    end
    else if (!mode[1])
    begin
      eff_addr = stepped;
      next_ptr = stepped;
    end
    else
    begin
      eff_addr = ptr;
      next_ptr = stepped;
    end
  end

endmodule : pointer_step

// ### data_store.sv
// flip-flop data memory, one write port and two read ports
`timescale 1ns/1ps
module data_store
  import move_exec_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write port
  input wire logic we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read ports
  input wire logic [MEM_AW-1:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [MEM_AW-1:0] raddr_b,
  output logic [7:0] rdata_b
);

  logic [7:0] cells [MEM_DEPTH];

  // ========================================================================
  // storage
  for (genvar i = 0; i < MEM_DEPTH; i++)
  begin : g_cell
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        cells[i] <= RST_BYTE;
      else if (we && waddr == MEM_AW'(i))
        cells[i] <= wdata;
    end
  end

  assign rdata_a = cells[raddr_a];
  assign rdata_b = cells[raddr_b];

endmodule : data_store

// ### indirect_and_literal_moves.sv
// data-move instruction execution with an axi4-lite register slave
`timescale 1ns/1ps
module indirect_and_literal_moves
  import move_exec_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ========================================================================
  // state
  logic [7:0] aw_addr;
  logic aw_held;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [31:0] wr_word;
  logic [31:0] aw_cur;
  logic [31:0] mask;

  logic [31:0] instr;
  logic [7:0] acc;
  logic [STAT_W-1:0] status;
  logic [BANK_W-1:0] bank;
  logic [PAGE_W-1:0] page;
  logic [PTR_W-1:0] ptr [NUM_PTR];
  logic [PTR_W-1:0] eff [NUM_PTR];
  logic [PTR_W-1:0] nxt [NUM_PTR];
  logic [MEM_AW-1:0] mem_addr;
  logic [PTR_W-1:0] pc;

  // ========================================================================
  // decoded instruction, taken from the word being written
  logic exec;
  op_e op;
  logic psel;
  logic [1:0] mode;
  logic rel;
  logic [7:0] lit;
  logic [FILE_W-1:0] faddr;
  logic [PTR_W-1:0] ptr_eff;
  logic [MEM_AW-1:0] file_target;
  logic is_alias;

  assign exec = wr_go && aw_addr == OFF_INSTR;
  assign op = op_e'(wr_word[OP_LSB +: OP_W]);
  assign psel = wr_word[PSEL_BIT];
  assign mode = wr_word[MODE_LSB +: 2];
  assign rel = wr_word[REL_BIT];
  assign lit = wr_word[LIT_LSB +: 8];
  assign faddr = wr_word[LIT_LSB +: FILE_W];

  // ========================================================================
  // memory and pointer units
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem_rd_ptr;
  logic [7:0] mem_rd_win;

  data_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr_a(ptr_eff[MEM_AW-1:0]),
    .rdata_a(mem_rd_ptr),
    .raddr_b(mem_addr),
    .rdata_b(mem_rd_win)
  );

  for (genvar i = 0; i < NUM_PTR; i++)
  begin : g_ptr
    pointer_step u_step (
      .ptr(ptr[i]),
      .mode(mode),
      .rel(rel),
      .offset(wr_word[LIT_LSB +: OFFS_W]),
      .eff_addr(eff[i]),
      .next_ptr(nxt[i])
    );

    // a bus write and an instruction are both wr_go events, never together
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        ptr[i] <= RST_PTR;
      else if (exec && (op == OP_LOAD_PTR || op == OP_STORE_PTR)
               && psel == 1'(i))
        ptr[i] <= nxt[i];
      else if (wr_go && aw_addr == ((i == 1) ? OFF_PTR1 : OFF_PTR0))
        ptr[i] <= wr_word[PTR_W-1:0];
    end
  end

  assign ptr_eff = eff[psel];

  // alias addresses in the file space reach memory through a pointer
  assign is_alias = faddr == ALIAS0 || faddr == ALIAS1;
  always_comb
  begin
    if (is_alias)
      file_target = ptr[faddr[0]][MEM_AW-1:0];
    else
      file_target = MEM_AW'({bank, faddr});
  end

  always_comb
  begin
    mem_we = 1'b0;
    mem_wa = mem_addr;
    mem_wd = wr_word[7:0];
    if (exec && op == OP_STORE_PTR)
    begin
      mem_we = 1'b1;
      mem_wa = ptr_eff[MEM_AW-1:0];
      mem_wd = acc;
    end
    else if (exec && op == OP_STORE_FILE)
    begin
      mem_we = 1'b1;
      mem_wa = file_target;
      mem_wd = acc;
    end
    else if (wr_go && aw_addr == OFF_MDATA)
      mem_we = 1'b1;
  end

  // ========================================================================
  // core registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      acc <= RST_BYTE;
    else if (exec && op == OP_LOAD_PTR)
      acc <= mem_rd_ptr;
    else if (exec && op == OP_LOAD_LIT)
      acc <= lit;
    else if (wr_go && aw_addr == OFF_ACC)
      acc <= wr_word[7:0];
  end

  // of the instructions only a pointer load touches a flag; pointer stepping never does
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= RST_STAT;
    else if (exec && op == OP_LOAD_PTR)
      status[STAT_Z] <= mem_rd_ptr == RST_BYTE;
    else if (wr_go && aw_addr == OFF_STATUS)
      status <= wr_word[STAT_W-1:0];
  end

  // literal field wider than the legal range keeps only its low bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bank <= BANK_W'(RST_BYTE);
    else if (exec && op == OP_SET_BANK)
      bank <= lit[BANK_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      page <= PAGE_W'(RST_BYTE);
    else if (exec && op == OP_SET_PAGE)
      page <= lit[PAGE_W-1:0];
  end

  // every instruction here is one word and one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pc <= RST_PTR;
    else if (exec)
      pc <= pc + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      instr <= RST_WORD;
    else if (exec)
      instr <= wr_word;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mem_addr <= RST_BYTE;
    else if (wr_go && aw_addr == OFF_MADDR)
      mem_addr <= wr_word[MEM_AW-1:0];
  end

  // ========================================================================
  // register read view
  function automatic logic [31:0] reg_value(input logic [7:0] a);
    logic [31:0] v;
    v = RST_WORD;
    case (a)
      OFF_INSTR: v = instr;
      OFF_ACC: v = 32'(acc);
      OFF_STATUS: v = 32'(status);
      OFF_BANK: v = 32'(bank);
      OFF_PAGE: v = 32'(page);
      OFF_PTR0: v = 32'(ptr[0]);
      OFF_PTR1: v = 32'(ptr[1]);
      OFF_MADDR: v = 32'(mem_addr);
      OFF_MDATA: v = 32'(mem_rd_win);
      OFF_PC: v = 32'(pc);
      default: v = RST_WORD;
    endcase
    return v;
  endfunction : reg_value

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= OFF_PC;
  endfunction : mapped

  // ========================================================================
  // write channels: address and data taken in either order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_go = aw_held && w_held;

  // byte enables merge into the current value so partial writes are safe
  assign aw_cur = reg_value(aw_addr);
  for (genvar b = 0; b < 4; b++)
  begin : g_mask
    assign mask[8*b +: 8] = {8{w_strb[b]}};
  end
  assign wr_word = (aw_cur & ~mask) | (w_data & mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= RST_BYTE;
    end
    else if (wr_go)
      aw_held <= 1'b0;
    else if (awvalid && awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= RST_WORD;
      w_strb <= 4'h0;
    end
    else if (wr_go)
      w_held <= 1'b0;
    else if (wvalid && wready)
    begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end
  end

  // read-only and unmapped words still answer, the latter with slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ========================================================================
  // read channel
  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= RST_WORD;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= reg_value(araddr);
      rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule : indirect_and_literal_moves

// ### move_exec_monitor.sv
// bus-level checker for the data-move execution block
`timescale 1ns/1ps
module move_exec_monitor
  import move_exec_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  // ========================================================================
  // properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_reset_idle: assert property (
    $rose(aresetn) |-> !bvalid && !rvalid)
    else $error("response pending after reset");
  chk_write_done: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered in time");
  chk_bad_write: assert property (
    awvalid && awready && wvalid && wready && awaddr > 8'h24
    |-> ##[1:2] (bvalid && bresp == RESP_SLVERR))
    else $error("unmapped write not refused");
  chk_b_release: assert property (
    bvalid && bready |=> !bvalid)
    else $error("write response not released");
  chk_w_block: assert property (
    bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_read_turn: assert property (
    arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  chk_ar_block: assert property (
    rvalid |-> !arready)
    else $error("read taken while data pending");
  chk_r_release: assert property (
    rvalid && rready |=> !rvalid)
    else $error("read data not released");
  chk_bad_read: assert property (
    arvalid && arready && araddr > 8'h24
    |=> rresp == RESP_SLVERR && rdata == RST_WORD)
    else $error("unmapped read not refused");
  chk_good_read: assert property (
    arvalid && arready && araddr <= 8'h24 && araddr[1:0] == 2'b00
    |=> rresp == RESP_OKAY)
    else $error("mapped read refused");
endmodule : move_exec_monitor

bind indirect_and_literal_moves move_exec_monitor u_mon (.aclk, .aresetn,
  .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

// ### indirect_and_literal_moves_tb.sv
// self-checking testbench for the data-move execution block
`timescale 1ns/1ps
module indirect_and_literal_moves_tb
  import move_exec_pkg::*;
;
  // ========================================================================
  // signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [2:0] awprot = 3'h0;
  logic [2:0] arprot = 3'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors = 0;
  int compares = 0;

  always #10 aclk = ~aclk;

  indirect_and_literal_moves u_dut (.aclk, .aresetn, .awaddr, .awprot,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);

  // ========================================================================
  // bus tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // ready is sampled mid-cycle so the release lands just after the edge
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    for (n = 0; n < 50 && !bh; n++)
    begin
      @(negedge aclk);
      ah = awvalid && (awready === 1'b1);
      wh = wvalid && (wready === 1'b1);
      bh = (bvalid === 1'b1);
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    if (!bh) chk("write timeout", 32'h0, 32'h1);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    for (n = 0; n < 50 && !rh; n++)
    begin
      @(negedge aclk);
      ah = arvalid && (arready === 1'b1);
      rh = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
    if (!rh) chk("read timeout", 32'h0, 32'h1);
  endtask : rd

  task w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : w

  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, d, e);
  endtask : rc

  task ex(input logic [2:0] op, input logic p, input logic [1:0] m,
    input logic rl, input logic [7:0] k);
    w(OFF_INSTR, {16'h0, k, 1'b0, rl, m, p, op});
  endtask : ex

  task mset(input logic [7:0] a, input logic [7:0] v);
    w(OFF_MADDR, {24'h0, a});
    w(OFF_MDATA, {24'h0, v});
  endtask : mset

  // ========================================================================
  // scenarios
  task t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rc("acc", OFF_ACC, 32'h0);
    rc("ptr0", OFF_PTR0, 32'h0);
    rd(8'h28, d, r);
    chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("rdata", d, RST_WORD);
    wr(8'h30, 32'h1, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : t_reset

  task t_literals;
    w(OFF_STATUS, 32'h7);
    ex(OP_LOAD_LIT, 1'b0, 2'b00, 1'b0, 8'hff);
    rc("acc", OFF_ACC, 32'hff);
    ex(OP_SET_BANK, 1'b0, 2'b00, 1'b0, 8'h2f);
    rc("bank", OFF_BANK, 32'h0f);
    ex(OP_SET_PAGE, 1'b0, 2'b00, 1'b0, 8'hff);
    rc("page", OFF_PAGE, 32'h7f);
    rc("flags", OFF_STATUS, 32'h7);
    w(OFF_BANK, 32'h3);
    rc("bank ro", OFF_BANK, 32'h0f);
  endtask : t_literals

  // every start value sits at an end so each step wraps
  task t_modes;
    logic [15:0] b, nx, e;
    logic [7:0] v, pa;
    for (int i = 0; i < 8; i++)
    begin
      b = i[0] ? 16'h0000 : 16'hffff;
      nx = i[0] ? b - 16'h1 : b + 16'h1;
      e = i[1] ? b : nx;
      v = 8'(i * 33);
      pa = i[2] ? OFF_PTR1 : OFF_PTR0;
      w(pa, {16'h0, b});
      w(OFF_STATUS, 32'h3);
      mset(e[7:0], v);
      ex(OP_LOAD_PTR, i[2], i[1:0], 1'b0, 8'h00);
      rc("ld acc", OFF_ACC, {24'h0, v});
      rc("ld flags", OFF_STATUS, {29'h0, v == 8'h0, 2'b11});
      rc("ld ptr", pa, {16'h0, nx});
      w(pa, {16'h0, b});
      w(OFF_ACC, {24'h0, ~v});
      ex(OP_STORE_PTR, i[2], i[1:0], 1'b0, 8'h00);
      rc("st mem", OFF_MDATA, {24'h0, ~v});
      rc("st flags", OFF_STATUS, {29'h0, v == 8'h0, 2'b11});
      rc("st ptr", pa, {16'h0, nx});
    end
  endtask : t_modes

  task t_offset;
    for (int j = 0; j < 2; j++)
    begin
      w(OFF_PTR1, 32'h40);
      w(OFF_ACC, 32'h70 + j);
      ex(OP_STORE_PTR, 1'b1, 2'b10, 1'b1, j ? 8'h1f : 8'h20);
      w(OFF_MADDR, j ? 32'h5f : 32'h20);
      rc("rel mem", OFF_MDATA, 32'h70 + j);
      rc("rel ptr", OFF_PTR1, 32'h40);
    end
  endtask : t_offset

  task t_file;
    ex(OP_SET_BANK, 1'b0, 2'b00, 1'b0, 8'h01);
    w(OFF_ACC, 32'h5a);
    ex(OP_STORE_FILE, 1'b0, 2'b00, 1'b0, 8'h10);
    w(OFF_MADDR, 32'h90);
    rc("file", OFF_MDATA, 32'h5a);
    w(OFF_PTR0, 32'h33);
    ex(OP_STORE_FILE, 1'b0, 2'b00, 1'b0, {1'b0, ALIAS0});
    w(OFF_MADDR, 32'h33);
    rc("alias", OFF_MDATA, 32'h5a);
    rc("alias ptr", OFF_PTR0, 32'h33);
  endtask : t_file

  task t_nop;
    logic [31:0] pc0;
    logic [1:0] r;
    rd(OFF_PC, pc0, r);
    ex(OP_NOP, 1'b0, 2'b00, 1'b0, 8'hff);
    ex(OP_RSVD, 1'b0, 2'b00, 1'b0, 8'hff);
    rc("pc", OFF_PC, pc0 + 32'h2);
    rc("nop acc", OFF_ACC, 32'h5a);
  endtask : t_nop

  // ========================================================================
  // run control
  task finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_literals;
    t_modes;
    t_offset;
    t_file;
    t_nop;
    finish_test;
  end

  // the whole run needs well under a tenth of this span
  initial
  begin
    #400000;
    errors++;
    finish_test;
  end
endmodule : indirect_and_literal_moves_tb
